// ### common/tree_cmd_regs.vh
/*
  Constants of the tree command parser: session port, line storage size,
  character codes, command and item kind codes, reply prefixes.
  Assumes inclusion by bare name from the design files and the bench.
*/
`ifndef TREE_CMD_REGS_VH
`define TREE_CMD_REGS_VH

// ==========================================================
// session and storage
`define TCP_LISTEN_PORT 16'h17DB
`define LINE_ADDR_W     6

// ==========================================================
// character codes
`define CH_TAB   8'h09
`define CH_LF    8'h0A
`define CH_CR    8'h0D
`define CH_SP    8'h20
`define CH_HASH  8'h23
`define CH_PCT   8'h25
`define CH_LPAR  8'h28
`define CH_RPAR  8'h29
`define CH_DOT   8'h2E
`define CH_SLASH 8'h2F
`define CH_COLON 8'h3A
`define CH_EQ    8'h3D
`define CH_E     8'h45
`define CH_BSL   8'h5C
`define CH_LOW_M 8'h6D
`define CH_LOW_N 8'h6E
`define CH_LOW_P 8'h70
`define CH_LBRC  8'h7B
`define CH_RBRC  8'h7D

// ==========================================================
// command words, right aligned in 48 bits
`define WORD_QUERY  48'h000000474554
`define WORD_BULK   48'h474554414C4C
`define WORD_MODIFY 48'h000000534554
`define WORD_INVOKE 48'h000043414C4C
`define WORD_MANUAL 48'h0000004D414E

// ==========================================================
// command codes toward the tree
`define CMD_QUERY  3'h0
`define CMD_BULK   3'h1
`define CMD_MODIFY 3'h2
`define CMD_INVOKE 3'h3
`define CMD_MANUAL 3'h4
`define CMD_NONE   3'h7

// ==========================================================
// addressed item kinds
`define KIND_NODE 2'h0
`define KIND_PROP 2'h1
`define KIND_METH 2'h2

// ==========================================================
// reply prefixes
`define PFX_PROP_RW 16'h7077

// ==========================================================
// syntax error text length
`define ERR_TEXT_LEN 4'hD

`endif

// ### core/char_class.v
/*
  Character classifier for one byte: letter or digit, hex digit,
  protocol control character needing a backslash.
  Assumes a stable byte on its input; purely combinational.
*/
`timescale 1ns/1ps
`include "tree_cmd_regs.vh"
module char_class (
  // byte under test
  input  wire [7:0] ch,
  // classes
  output wire       is_alnum,
  output wire       is_hex,
  output wire       is_ctrl
);

  wire digit;
  wire upper;
  wire lower;

  assign digit    = (ch >= 8'h30) && (ch <= 8'h39);
  assign upper    = (ch >= 8'h41) && (ch <= 8'h5A);
  assign lower    = (ch >= 8'h61) && (ch <= 8'h7A);
  assign is_alnum = digit || upper || lower;
  assign is_hex   = digit || ((ch >= 8'h41) && (ch <= 8'h46)) || ((ch >= 8'h61) && (ch <= 8'h66));
  // escape set
  assign is_ctrl  = (ch == `CH_BSL) || (ch == `CH_LBRC) || (ch == `CH_RBRC) || (ch == `CH_HASH)
                 || (ch == `CH_PCT) || (ch == `CH_LPAR) || (ch == `CH_RPAR) || (ch == `CH_CR)
                 || (ch == `CH_LF) || (ch == `CH_TAB);

endmodule // char_class

// ### core/tree_cmd_parser.v
/*
  Line based command interpreter for a node/property/method tree.
  Assumes byte streams from and to a TCP session on sys_clk, and a tree
  store outside that answers requests with prefixed reply lines.
*/
// Functional notes
// - lines end with CR LF both ways
// - names compared case-sensitively
// - path from root, slash between levels
// - node names letters and digits only
// - session on TCP port 6107
// - query lists node, or property value after dot
// - bulk query lists all members, one line each
// - modify echoes path and new value with pw
// - invoke: colon, method, parenthesised arguments
// - method reply m0 on success, mF on failure
// - manual reply prefixed nm, pm or mm
// - two-character type prefix on every reply line except the group open and close lines
// - error: percent, E, digits, colon, text
// - backslash removed, next character literal
// - escape set: backslash braces hash percent parens CR LF tab
// - optional four hex digit signature and hash
// - signed reply: brace plus signature, then closing brace
// - group lines also end with CR LF
`timescale 1ns/1ps
`include "tree_cmd_regs.vh"
module tree_cmd_parser #(
  parameter ADDR_W = `LINE_ADDR_W
) (
  // clock and reset
  input  wire              sys_clk,
  input  wire              reset,
  // command bytes from the session
  input  wire [7:0]        rx_data,
  input  wire              rx_valid,
  output reg               rx_ready,
  // reply bytes to the session
  output reg  [7:0]        tx_data,
  output reg               tx_valid,
  input  wire              tx_ready,
  // session setup
  output reg  [15:0]       listen_port,
  // request to the tree
  output reg               req_valid,
  output reg  [2:0]        req_cmd,
  output reg  [1:0]        req_kind,
  output reg  [ADDR_W:0]   req_path_end,
  output reg  [ADDR_W:0]   req_val_start,
  output reg  [ADDR_W:0]   req_val_end,
  // line storage read port for the tree
  input  wire [ADDR_W-1:0] path_rd_addr,
  output reg  [7:0]        path_rd_data,
  // reply line headers from the tree
  input  wire              rep_valid,
  input  wire [15:0]       rep_prefix,
  input  wire              rep_last,
  output reg               rep_ready,
  // reply line text from the tree
  input  wire              txt_valid,
  input  wire [7:0]        txt_data,
  input  wire              txt_end,
  output reg               txt_ready
);

  localparam [ADDR_W:0] DEPTH = {1'b1, {ADDR_W{1'b0}}};
  localparam [ADDR_W:0] ZERO  = {(ADDR_W+1){1'b0}};

  localparam [3:0] ST_DONE  = 4'h0;
  localparam [3:0] ST_RX    = 4'h1;
  localparam [3:0] ST_EXEC  = 4'h2;
  localparam [3:0] ST_OPEN  = 4'h3;
  localparam [3:0] ST_REQ   = 4'h4;
  localparam [3:0] ST_WAIT  = 4'h5;
  localparam [3:0] ST_PFX   = 4'h6;
  localparam [3:0] ST_ECHO  = 4'h7;
  localparam [3:0] ST_TXT   = 4'h8;
  localparam [3:0] ST_VAL   = 4'h9;
  localparam [3:0] ST_ERR   = 4'hA;
  localparam [3:0] ST_EOL   = 4'hB;
  localparam [3:0] ST_CLOSE = 4'hC;

  localparam [2:0] P_WORD = 3'h0;
  localparam [2:0] P_PATH = 3'h1;
  localparam [2:0] P_MEMB = 3'h2;
  localparam [2:0] P_VAL  = 3'h3;
  localparam [2:0] P_ARG  = 3'h4;

  // ==========================================================
  // state
  reg [7:0]      line_mem [0:(1<<ADDR_W)-1];
  reg [3:0]      state;
  reg [2:0]      phase;
  reg [3:0]      cnt;
  reg [47:0]     word_sh;
  reg [2:0]      word_len;
  reg            hex_all;
  reg            signed_cmd;
  reg [31:0]     sig;
  reg            esc_next;
  reg            cr_seen;
  reg            bad;
  reg            own_err;
  reg [ADDR_W:0] wr;
  reg [ADDR_W:0] rd;
  reg [15:0]     prefix;
  reg            last;
  reg            esc_pend;

  wire       can;
  wire       lit;
  wire       drop;
  wire       rx_alnum;
  wire       rx_hex;
  wire [7:0] rd_ch;
  wire       rd_ctrl;
  wire       line_bad;
  reg  [2:0] word_cmd;
  reg  [7:0] err_ch;

  assign can   = !tx_valid || tx_ready;
  assign lit   = esc_next;
  assign drop  = !lit && (rx_data == `CH_BSL || rx_data == `CH_CR);
  assign rd_ch = line_mem[rd[ADDR_W-1:0]];

  char_class rx_class (
    .ch       (rx_data),
    .is_alnum (rx_alnum),
    .is_hex   (rx_hex),
    .is_ctrl  ()
  );

  char_class out_class (
    .ch       (rd_ch),
    .is_alnum (),
    .is_hex   (),
    .is_ctrl  (rd_ctrl)
  );

  // ==========================================================
  // command word decode, exact bytes
  always @*
  begin
    word_cmd = `CMD_NONE;
    if (word_len == 3'h3 && word_sh == `WORD_QUERY)
      word_cmd = `CMD_QUERY;
    else if (word_len == 3'h6 && word_sh == `WORD_BULK)
      word_cmd = `CMD_BULK;
    else if (word_len == 3'h3 && word_sh == `WORD_MODIFY)
      word_cmd = `CMD_MODIFY;
    else if (word_len == 3'h4 && word_sh == `WORD_INVOKE)
      word_cmd = `CMD_INVOKE;
    else if (word_len == 3'h3 && word_sh == `WORD_MANUAL)
      word_cmd = `CMD_MANUAL;
  end

  // command and selector must agree
  assign line_bad = bad || (phase == P_WORD) || (req_cmd == `CMD_NONE)
                 || ((req_cmd == `CMD_MODIFY) != (phase == P_VAL))
                 || ((req_cmd == `CMD_INVOKE) != (phase == P_ARG));

  // parser error text " %E001:Syntax"
  always @*
  begin
    case (cnt)
      4'h0:    err_ch = `CH_SP;
      4'h1:    err_ch = `CH_PCT;
      4'h2:    err_ch = `CH_E;
      4'h3:    err_ch = 8'h30;
      4'h4:    err_ch = 8'h30;
      4'h5:    err_ch = 8'h31;
      4'h6:    err_ch = `CH_COLON;
      4'h7:    err_ch = 8'h53;
      4'h8:    err_ch = 8'h79;
      4'h9:    err_ch = 8'h6E;
      4'hA:    err_ch = 8'h74;
      4'hB:    err_ch = 8'h61;
      default: err_ch = 8'h78;
    endcase
  end

  // ==========================================================
  // line storage, written only while receiving
  always @(posedge sys_clk)
  begin
    if (state == ST_RX && rx_valid && phase != P_WORD && wr != DEPTH && !drop)
      line_mem[wr[ADDR_W-1:0]] <= rx_data;
    path_rd_data <= line_mem[path_rd_addr];
  end

  // ==========================================================
  // receive, request and reply sequencing
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      state         <= ST_DONE;
      rx_ready      <= 1'b0;
      tx_data       <= 8'h00;
      tx_valid      <= 1'b0;
      listen_port   <= 16'h0000;
      req_valid     <= 1'b0;
      req_cmd       <= `CMD_NONE;
      req_kind      <= `KIND_NODE;
      req_path_end  <= ZERO;
      req_val_start <= ZERO;
      req_val_end   <= ZERO;
      rep_ready     <= 1'b0;
      txt_ready     <= 1'b0;
      rd            <= ZERO;
      cnt           <= 4'h0;
      prefix        <= 16'h0000;
      last          <= 1'b0;
      own_err       <= 1'b0;
      esc_pend      <= 1'b0;
    end
    else
    begin
      listen_port <= `TCP_LISTEN_PORT;
      req_valid   <= 1'b0;
      if (tx_ready)
        tx_valid <= 1'b0;
      case (state)
        ST_DONE:
        begin
          phase         <= P_WORD;
          word_sh       <= 48'h0;
          word_len      <= 3'h0;
          hex_all       <= 1'b1;
          signed_cmd    <= 1'b0;
          esc_next      <= 1'b0;
          cr_seen       <= 1'b0;
          bad           <= 1'b0;
          wr            <= ZERO;
          req_cmd       <= `CMD_NONE;
          req_kind      <= `KIND_NODE;
          req_path_end  <= ZERO;
          req_val_start <= ZERO;
          req_val_end   <= ZERO;
          rx_ready      <= 1'b1;
          state         <= ST_RX;
        end
        ST_RX:
        begin
          if (rx_valid)
          begin
            cr_seen  <= !lit && rx_data == `CH_CR;
            esc_next <= !lit && rx_data == `CH_BSL;
            if (phase != P_WORD && !drop)
            begin
              if (wr == DEPTH)
                bad <= 1'b1;
              else
                wr <= wr + 1'b1;
            end
            if (!lit && rx_data == `CH_LF && cr_seen)
            begin
              rx_ready <= 1'b0;
              state    <= ST_EXEC;
            end
            else if (drop)
              bad <= bad;
            else
            begin
              case (phase)
                P_WORD:
                begin
                  if (lit)
                    bad <= 1'b1;
                  else if (rx_data == `CH_SP)
                  begin
                    req_cmd <= word_cmd;
                    phase   <= P_PATH;
                  end
                  else if (rx_data == `CH_HASH && !signed_cmd && word_len == 3'h4 && hex_all)
                  begin
                    signed_cmd <= 1'b1;
                    sig        <= word_sh[31:0];
                    word_sh    <= 48'h0;
                    word_len   <= 3'h0;
                  end
                  else
                  begin
                    word_sh  <= {word_sh[39:0], rx_data};
                    word_len <= (word_len == 3'h7) ? word_len : word_len + 3'h1;
                    hex_all  <= hex_all && rx_hex;
                  end
                end
                P_PATH:
                begin
                  req_path_end <= wr + 1'b1;
                  if (wr == ZERO && rx_data != `CH_SLASH)
                    bad <= 1'b1;
                  else if (!lit && rx_data == `CH_DOT)
                  begin
                    req_kind <= `KIND_PROP;
                    phase    <= P_MEMB;
                  end
                  else if (!lit && rx_data == `CH_COLON)
                  begin
                    req_kind <= `KIND_METH;
                    phase    <= P_MEMB;
                  end
                  else if (lit || !(rx_alnum || rx_data == `CH_SLASH))
                    bad <= 1'b1;
                end
                P_MEMB:
                begin
                  if (!lit && (rx_data == `CH_EQ || rx_data == `CH_LPAR))
                  begin
                    req_val_start <= wr + 1'b1;
                    req_val_end   <= wr + 1'b1;
                    phase         <= (rx_data == `CH_EQ) ? P_VAL : P_ARG;
                  end
                  else
                    req_path_end <= wr + 1'b1;
                end
                P_VAL:
                  req_val_end <= wr + 1'b1;
                default:
                begin
                  if (lit || rx_data != `CH_RPAR)
                    req_val_end <= wr + 1'b1;
                end
              endcase
            end
          end
        end
        ST_EXEC:
        begin
          if (phase == P_WORD && word_len == 3'h0 && !signed_cmd && !bad)
            state <= ST_DONE;
          else
          begin
            own_err <= line_bad;
            prefix  <= {(req_kind == `KIND_PROP) ? `CH_LOW_P :
                        (req_kind == `KIND_METH) ? `CH_LOW_M : `CH_LOW_N, `CH_E};
            last    <= 1'b1;
            cnt     <= 4'h0;
            state   <= signed_cmd ? ST_OPEN : (line_bad ? ST_PFX : ST_REQ);
          end
        end
        ST_OPEN:
        begin
          if (can)
          begin
            tx_valid <= 1'b1;
            cnt      <= cnt + 4'h1;
            case (cnt)
              4'h0:    tx_data <= `CH_LBRC;
              4'h1:    tx_data <= sig[31:24];
              4'h2:    tx_data <= sig[23:16];
              4'h3:    tx_data <= sig[15:8];
              4'h4:    tx_data <= sig[7:0];
              4'h5:    tx_data <= `CH_CR;
              default: tx_data <= `CH_LF;
            endcase
            if (cnt == 4'h6)
            begin
              cnt   <= 4'h0;
              state <= own_err ? ST_PFX : ST_REQ;
            end
          end
        end
        ST_REQ:
        begin
          req_valid <= 1'b1;
          rep_ready <= 1'b1;
          state     <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (rep_valid && rep_ready)
          begin
            rep_ready <= 1'b0;
            prefix    <= rep_prefix;
            last      <= rep_last;
            cnt       <= 4'h0;
            state     <= ST_PFX;
          end
        end
        ST_PFX:
        begin
          if (can)
          begin
            tx_valid <= 1'b1;
            cnt      <= cnt + 4'h1;
            tx_data  <= (cnt == 4'h0) ? prefix[15:8] : (cnt == 4'h1) ? prefix[7:0] : `CH_SP;
            if (cnt == 4'h2)
            begin
              rd    <= ZERO;
              state <= ST_ECHO;
            end
          end
        end
        ST_ECHO:
        begin
          if (rd == req_path_end)
          begin
            cnt       <= 4'h0;
            txt_ready <= 1'b0;
            state     <= own_err ? ST_ERR : ST_TXT;
          end
          else if (can)
          begin
            tx_valid <= 1'b1;
            tx_data  <= rd_ch;
            rd       <= rd + 1'b1;
          end
        end
        ST_TXT:
        begin
          if (txt_valid && txt_ready)
          begin
            txt_ready <= 1'b0;
            if (txt_end)
            begin
              rd       <= req_val_start;
              esc_pend <= 1'b0;
              state    <= (req_cmd == `CMD_MODIFY && prefix == `PFX_PROP_RW) ? ST_VAL : ST_EOL;
            end
            else
            begin
              tx_valid <= 1'b1;
              tx_data  <= txt_data;
            end
          end
          else
            txt_ready <= can;
        end
        ST_VAL:
        begin
          if (can)
          begin
            if (cnt == 4'h0)
            begin
              tx_valid <= 1'b1;
              tx_data  <= `CH_EQ;
              cnt      <= 4'h1;
            end
            else if (rd == req_val_end)
            begin
              cnt   <= 4'h0;
              state <= ST_EOL;
            end
            else if (rd_ctrl && !esc_pend)
            begin
              tx_valid <= 1'b1;
              tx_data  <= `CH_BSL;
              esc_pend <= 1'b1;
            end
            else
            begin
              tx_valid <= 1'b1;
              tx_data  <= rd_ch;
              esc_pend <= 1'b0;
              rd       <= rd + 1'b1;
            end
          end
        end
        ST_ERR:
        begin
          if (can)
          begin
            tx_valid <= 1'b1;
            tx_data  <= err_ch;
            cnt      <= cnt + 4'h1;
            if (cnt == `ERR_TEXT_LEN - 4'h1)
            begin
              cnt   <= 4'h0;
              state <= ST_EOL;
            end
          end
        end
        ST_EOL:
        begin
          if (can)
          begin
            tx_valid <= 1'b1;
            tx_data  <= (cnt == 4'h0) ? `CH_CR : `CH_LF;
            cnt      <= cnt + 4'h1;
            if (cnt == 4'h1)
            begin
              cnt       <= 4'h0;
              rep_ready <= !last;
              state     <= !last ? ST_WAIT : (signed_cmd ? ST_CLOSE : ST_DONE);
            end
          end
        end
        ST_CLOSE:
        begin
          if (can)
          begin
            tx_valid <= 1'b1;
            tx_data  <= (cnt == 4'h0) ? `CH_RBRC : (cnt == 4'h1) ? `CH_CR : `CH_LF;
            cnt      <= cnt + 4'h1;
            if (cnt == 4'h2)
              state <= ST_DONE;
          end
        end
        default:
          state <= ST_DONE;
      endcase
    end
  end

endmodule // tree_cmd_parser

// ### sim/tree_cmd_parser_monitor.sv
/*
  Port assertions of the tree command parser.
  Assumes a bind onto tree_cmd_parser and a single clock domain.
*/
`timescale 1ns/1ps
module tree_cmd_parser_monitor #(
  parameter ADDR_W = 6
) (
  // clock and reset
  input wire            sys_clk,
  input wire            reset,
  // session
  input wire [7:0]      rx_data,
  input wire            rx_valid,
  input wire            rx_ready,
  input wire [7:0]      tx_data,
  input wire            tx_valid,
  input wire            tx_ready,
  input wire [15:0]     listen_port,
  // tree side
  input wire            req_valid,
  input wire [2:0]      req_cmd,
  input wire [1:0]      req_kind,
  input wire [ADDR_W:0] req_path_end,
  input wire            rep_valid,
  input wire [15:0]     rep_prefix,
  input wire            rep_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // last two taken bytes, high byte of last taken prefix
  reg [7:0] p1;
  reg [7:0] p2;
  reg [7:0] hi;
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      p1 <= 8'h00;
      p2 <= 8'h00;
    end
    else if (rx_valid && rx_ready)
    begin
      p1 <= rx_data;
      p2 <= p1;
    end
    if (rep_valid && rep_ready)
      hi <= rep_prefix[15:8];
  end
  // ==========================================================
  // properties
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !tx_valid && !req_valid && !rx_ready && req_cmd == 3'h7)
    else $error("outputs not idle after reset");
  a_port_value: assert property (!reset |=> listen_port == 16'h17DB)
    else $error("listen port wrong");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte not held");
  a_req_pulse: assert property (req_valid |=> !req_valid)
    else $error("request longer than one cycle");
  a_req_steady: assert property (rep_ready && !req_valid |-> $stable(req_cmd) && $stable(req_kind) && $stable(req_path_end))
    else $error("request fields moved during reply");
  a_rx_closed: assert property (rep_ready |-> !rx_ready)
    else $error("receiving during reply");
  a_line_end: assert property (rx_valid && rx_ready && rx_data == 8'h0A && p1 == 8'h0D && p2 != 8'h5C |=> !rx_ready)
    else $error("line end not closing input");
  a_prefix_out: assert property (rep_valid && rep_ready |=> ##[0:40] tx_valid && tx_data == hi)
    else $error("prefix not sent");
endmodule // tree_cmd_parser_monitor

bind tree_cmd_parser tree_cmd_parser_monitor #(.ADDR_W(ADDR_W)) tree_cmd_parser_monitor_i (
  .sys_clk(sys_clk), .reset(reset), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .listen_port(listen_port),
  .req_valid(req_valid), .req_cmd(req_cmd), .req_kind(req_kind), .req_path_end(req_path_end),
  .rep_valid(rep_valid), .rep_prefix(rep_prefix), .rep_ready(rep_ready));

// ### sim/session_client.sv
/*
  Remote client model: sends command lines byte by byte, gathers reply bytes.
  Assumes the parser clock; slow makes it accept every other cycle.
*/
`timescale 1ns/1ps
module session_client (
  // clock
  input  wire       sys_clk,
  // command bytes
  output reg  [7:0] rx_data = 8'hFF,
  output reg        rx_valid = 1'b0,
  input  wire       rx_ready,
  // reply bytes
  input  wire [7:0] tx_data,
  input  wire       tx_valid,
  output reg        tx_ready = 1'b1
);
  string got = "";
  reg    slow = 1'b0;
  always @(posedge sys_clk)
  begin
    if (tx_valid && tx_ready)
      got <= $sformatf("%s%c", got, tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // each byte held until taken; idle line shows inverse of last byte
  task send(input string s);
    int i;
    int n;
    begin
      for (i = 0; i < s.len(); i++)
      begin
        rx_valid <= 1'b1;
        rx_data  <= s[i];
        n = 0;
        do
        begin
          @(posedge sys_clk);
          n++;
        end
        while (!rx_ready && n < 200);
        if (!rx_ready)
          tree_cmd_parser_bench.hang;
      end
      rx_valid <= 1'b0;
      rx_data  <= ~s[s.len()-1];
    end
  endtask
endmodule // session_client

// ### sim/tree_cmd_parser_bench.sv
/*
  Self-checking bench of the tree command parser.
  Assumes the client model and the tree answers driven here.
*/
`timescale 1ns/1ps
`include "tree_cmd_regs.vh"
module tree_cmd_parser_bench;
  reg         sys_clk = 1'b0;
  reg         reset = 1'b1;
  wire [7:0]  rx_data;
  wire [7:0]  tx_data;
  wire [7:0]  path_rd_data;
  wire        rx_valid;
  wire        rx_ready;
  wire        tx_valid;
  wire        tx_ready;
  wire        req_valid;
  wire        rep_ready;
  wire        txt_ready;
  wire [15:0] listen_port;
  wire [2:0]  req_cmd;
  wire [1:0]  req_kind;
  wire [6:0]  req_path_end;
  wire [6:0]  req_val_start;
  wire [6:0]  req_val_end;
  reg  [5:0]  path_rd_addr = 6'h00;
  reg         rep_valid = 1'b0;
  reg         rep_last = 1'b0;
  reg         txt_valid = 1'b0;
  reg         txt_end = 1'b0;
  reg  [15:0] rep_prefix = 16'h0000;
  reg  [7:0]  txt_data = 8'h00;
  int         mismatches = 0;
  int         checks = 0;
  always #4 sys_clk = ~sys_clk;

  tree_cmd_parser #(.ADDR_W(6)) tree_cmd_parser_i (
    .sys_clk(sys_clk), .reset(reset), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .listen_port(listen_port),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_kind(req_kind), .req_path_end(req_path_end),
    .req_val_start(req_val_start), .req_val_end(req_val_end), .path_rd_addr(path_rd_addr),
    .path_rd_data(path_rd_data), .rep_valid(rep_valid), .rep_prefix(rep_prefix), .rep_last(rep_last),
    .rep_ready(rep_ready), .txt_valid(txt_valid), .txt_data(txt_data), .txt_end(txt_end),
    .txt_ready(txt_ready));
  session_client session_client_i (
    .sys_clk(sys_clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

  // ==========================================================
  // shared tasks
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task hang;
    begin
      mismatches++;
      conclude;
    end
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      checks++;
      if (got !== exp)
      begin
        mismatches++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wait_text(input string exp);
    int n;
    begin
      n = 0;
      while (session_client_i.got.len() < exp.len() && n < 2000)
      begin
        @(posedge sys_clk);
        n++;
      end
      if (n == 2000)
        hang;
      checks++;
      if (session_client_i.got != exp)
      begin
        mismatches++;
        $display("wrong value at %0t: got %h expected %h", $time, session_client_i.got, exp);
      end
      session_client_i.got = "";
    end
  endtask
  task wait_req(input [2:0] c, input [1:0] k);
    int n;
    begin
      n = 0;
      while (!req_valid && n < 300)
      begin
        @(posedge sys_clk);
        n++;
      end
      if (n == 300)
        hang;
      chk(req_cmd, c);
      chk(req_kind, k);
    end
  endtask
  // one reply header then its text and end marker
  task answer(input [15:0] p, input string t, input bit last);
    int i;
    int n;
    begin
      rep_valid  <= 1'b1;
      rep_prefix <= p;
      rep_last   <= last;
      for (i = -1; i <= t.len(); i++)
      begin
        if (i >= 0)
        begin
          rep_valid <= 1'b0;
          txt_valid <= 1'b1;
          txt_end   <= (i == t.len());
          txt_data  <= (i < t.len()) ? t[i] : 8'h00;
        end
        n = 0;
        do
        begin
          @(posedge sys_clk);
          n++;
        end
        while (!((i < 0) ? rep_ready : txt_ready) && n < 300);
        if (n == 300)
          hang;
      end
      txt_valid <= 1'b0;
      txt_end   <= 1'b0;
    end
  endtask

  // ==========================================================
  // scenarios
  task t_query;
    begin
      session_client_i.send("GET /a.b\r\n");
      wait_req(`CMD_QUERY, `KIND_PROP);
      chk(req_path_end, 7'h04);
      answer("pr", "=5", 1'b1);
      wait_text("pr /a.b=5\r\n");
    end
  endtask
  task t_bulk;
    begin
      session_client_i.slow = 1'b1;
      session_client_i.send("\107ETALL /S\r\n");
      wait_req(`CMD_BULK, `KIND_NODE);
      answer("n-", "/x", 1'b0);
      answer("m-", ":r", 1'b1);
      wait_text("n- /S/x\r\nm- /S:r\r\n");
      session_client_i.slow = 1'b0;
    end
  endtask
  task t_modify;
    begin
      session_client_i.send("SET /p.v=a\\#b\r\n");
      wait_req(`CMD_MODIFY, `KIND_PROP);
      chk(req_val_end - req_val_start, 7'h03);
      path_rd_addr <= req_val_start[5:0] + 6'h01;
      repeat (2) @(posedge sys_clk);
      chk(path_rd_data, 8'h23);
      answer("pw", "", 1'b1);
      wait_text("pw /p.v=a\\#b\r\n");
    end
  endtask
  task t_invoke;
    begin
      session_client_i.send("1700#CALL /m:f(1)\r\n");
      wait_req(`CMD_INVOKE, `KIND_METH);
      answer("m0", "", 1'b1);
      wait_text("{1700\r\nm0 /m:f\r\n}\r\n");
      session_client_i.send("abCD#CALL /m:g()\r\n");
      wait_req(`CMD_INVOKE, `KIND_METH);
      answer("mF", "", 1'b1);
      wait_text("{abCD\r\nmF /m:g\r\n}\r\n");
    end
  endtask
  task t_manual;
    string pa [3] = '{"/n", "/n.p", "/n:m"};
    string ps [3] = '{"nm", "pm", "mm"};
    int i;
    begin
      for (i = 0; i < 3; i++)
      begin
        session_client_i.send({"\115AN ", pa[i], "\r\n"});
        wait_req(`CMD_MANUAL, i[1:0]);
        answer({ps[i][0], ps[i][1]}, " h", 1'b1);
        wait_text({ps[i], " ", pa[i], " h\r\n"});
      end
    end
  endtask
  task t_errors;
    begin
      session_client_i.send("get /a\r\n");
      wait_text("nE /a %E001:Syntax\r\n");
      session_client_i.send("GET /a-b\r\n");
      wait_text("nE /a-b %E001:Syntax\r\n");
      session_client_i.send("SET /a.b\r\n");
      wait_text("pE /a.b %E001:Syntax\r\n");
      session_client_i.send("CALL /m:f\r\n");
      wait_text("mE /m:f %E001:Syntax\r\n");
    end
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(listen_port, 16'h17DB);
    t_query;
    t_bulk;
    t_modify;
    t_invoke;
    t_manual;
    t_errors;
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(req_cmd, `CMD_NONE);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_query;
    conclude;
  end
endmodule // tree_cmd_parser_bench
